// *** common/system_reference_monitor_consts.svh ***
// Offsets, field positions, reset values and counts of the reference monitor
// and transmit gating register bank.
// Assumes a byte-wide register port with 12-bit addresses.
//
// Operation
// - Report reference-to-multiframe delay, two LSBs zero
// - Any delay/phase write snapshots measurements for readback
// - Count reference pulses; write clears count
// - Six-bit jitter window, low two bits ignored
// - Arrival variation beyond window raises jitter event
// - Mode monitor-only or realign every pulse
// - One-shot realigns once, then reverts to monitor
// - Input gate bit zeroes or passes lane data
// - Output gate bit passes or blocks core data
// - Oscillator reset from pin or hop bits
// - Output gating from pin or software bit
// - Input gating from pin or software bit
// - Full-scale current from pin or registers
// - Ten-bit full-scale code split, resets all ones
// - Two bias power-down bits, reset to one
// - Six-bit signed-magnitude clock phase trim field
// - Sticky jitter flag, enable gates the interrupt, write one clears
`ifndef SYSTEM_REFERENCE_MONITOR_CONSTS_SVH
`define SYSTEM_REFERENCE_MONITOR_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_IRQ_ENABLE     12'h020
`define ADDR_IRQ_STATUS     12'h024
`define ADDR_DELAY_LOW      12'h034
`define ADDR_DELAY_HIGH     12'h035
`define ADDR_PULSE_COUNT    12'h036
`define ADDR_PHASE_LOW      12'h037
`define ADDR_PHASE_HIGH     12'h038
`define ADDR_JITTER_WINDOW  12'h039
`define ADDR_SYNC_CONTROL   12'h03a
`define ADDR_TX_GATING      12'h03f
`define ADDR_BIAS_PD        12'h040
`define ADDR_FSC_LOW        12'h041
`define ADDR_FSC_HIGH       12'h042
`define ADDR_PHASE_TRIM     12'h07f

// ****************************************
// Field positions
// ****************************************
`define BIT_JITTER          4
`define BIT_SW_OUTPUT_GATE  7
`define BIT_SW_INPUT_GATE   6
`define BIT_PIN_OSC_RESET   3
`define BIT_PIN_OUTPUT_GATE 2
`define BIT_PIN_INPUT_GATE  1
`define BIT_PIN_CURRENT     0

// ****************************************
// Reset values
// ****************************************
`define RST_TX_GATING       8'hc0
`define RST_BIAS_PD         2'h3
`define RST_FSC_LOW         2'h3
`define RST_FSC_HIGH        8'hff

// ****************************************
// Counts
// ****************************************
`define MULTIFRAME_PERIOD   64
`define DELAY_MAX           12'hfff

`endif

// *** common/system_reference_monitor_pkg.sv ***
// Types shared by the reference monitor register bank.
// Assumes the constants header is included where offsets are needed.
package system_reference_monitor_pkg;

	// Synchronization mode codes
	typedef enum logic [1:0] {
		MODE_MONITOR    = 2'b00,
		MODE_CONTINUOUS = 2'b01,
		MODE_ONE_SHOT   = 2'b10,
		MODE_SPARE      = 2'b11
	} sync_mode_t;

endpackage

// *** design/system_reference_monitor_tx_gating_regs.sv ***
// Reference monitor, multiframe clock alignment, transmit gating and analog
// trim registers of the converter.
// Assumes a byte register port driven by the serial front end, and inputs
// synchronous to mclk.
`timescale 1ns/10ps
`include "system_reference_monitor_consts.svh"

module system_reference_monitor_tx_gating_regs #(
	parameter int DATA_W       = 16,
	parameter int FRAME_PERIOD = `MULTIFRAME_PERIOD
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              reset_n,
	// Register port
	input  wire logic [11:0]       reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [7:0]        reg_rdata,
	// Reference and phase capture
	input  wire logic              system_reference,
	input  wire logic [11:0]       ref_phase_value,
	output logic                   multiframe_clock,
	output logic                   jitter_irq,
	// Transmit gating
	input  wire logic              tx_enable,
	input  wire logic [1:0]        hop_mode_bits,
	input  wire logic [DATA_W-1:0] lane_data,
	input  wire logic [DATA_W-1:0] datapath_data,
	output logic      [DATA_W-1:0] datapath_in_data,
	output logic      [DATA_W-1:0] core_data,
	output logic                   osc_reset,
	// Analog controls
	output logic      [9:0]        full_scale_code,
	output logic      [1:0]        core_bias_off,
	output logic      [5:0]        clock_phase_trim
);

	// ****************************************
	// Parameter checks
	// ****************************************
	if (DATA_W < 1 || FRAME_PERIOD < 2 || FRAME_PERIOD > 4096) begin : g_bad_param
		$error("Parameter out of range");
	end

	localparam logic [11:0] FRAME_LAST = 12'(FRAME_PERIOD - 1);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0]                       rdata;
		logic                             ref_prev;
		logic [11:0]                      frame_cnt;
		logic                             frame_clk;
		logic                             meas_active;
		logic [11:0]                      meas_cnt;
		logic [11:0]                      live_delay;
		logic [11:0]                      prev_delay;
		logic                             have_prev;
		logic [11:0]                      snap_delay;
		logic [11:0]                      snap_phase;
		logic [7:0]                       pulse_count;
		logic [5:0]                       window;
		system_reference_monitor_pkg::sync_mode_t   mode;
		logic [7:0]                       tx_gating;
		logic                             jit_enable;
		logic                             jit_flag;
		logic                             irq;
		logic [1:0]                       bias_off;
		logic [1:0]                       fsc_low;
		logic [7:0]                       fsc_high;
		logic [5:0]                       trim;
		logic [DATA_W-1:0]                dp_in;
		logic [DATA_W-1:0]                dp_out;
		logic                             osc_rst;
		logic [9:0]                       fsc_out;
	} state_t;

	state_t s;
	state_t next_s;

	// Register read decode
	function automatic logic [7:0] read_mux(input logic [11:0] a, input state_t st);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`ADDR_IRQ_ENABLE:    v = {3'h0, st.jit_enable, 4'h0};
			`ADDR_IRQ_STATUS:    v = {3'h0, st.jit_flag, 4'h0};
			`ADDR_DELAY_LOW:     v = st.snap_delay[7:0];
			`ADDR_DELAY_HIGH:    v = {4'h0, st.snap_delay[11:8]};
			`ADDR_PULSE_COUNT:   v = st.pulse_count;
			`ADDR_PHASE_LOW:     v = st.snap_phase[7:0];
			`ADDR_PHASE_HIGH:    v = {4'h0, st.snap_phase[11:8]};
			`ADDR_JITTER_WINDOW: v = {2'h0, st.window};
			`ADDR_SYNC_CONTROL:  v = {6'h00, st.mode};
			`ADDR_TX_GATING:     v = {st.tx_gating[7:6], 2'h0, st.tx_gating[3:0]};
			`ADDR_BIAS_PD:       v = {6'h00, st.bias_off};
			`ADDR_FSC_LOW:       v = {6'h00, st.fsc_low};
			`ADDR_FSC_HIGH:      v = st.fsc_high;
			`ADDR_PHASE_TRIM:    v = {2'h0, st.trim};
			default:             v = 8'h00;
		endcase
		return v;
	endfunction

	function automatic logic wr_at(input logic w, input logic [11:0] a, input logic [11:0] t);
		return w && (a == t);
	endfunction

	// ****************************************
	// Combinational decode
	// ****************************************
	logic        ref_edge;
	logic        frame_rise;
	logic        meas_done;
	logic [11:0] delay_val;
	logic [11:0] delay_diff;
	logic [11:0] window_eff;
	logic        jit_event;
	logic        realign;
	logic        snapshot;
	logic        in_gate;
	logic        out_gate;

	always_comb begin
		ref_edge   = system_reference && !s.ref_prev;
		frame_rise = (s.frame_cnt == 12'h000);
		meas_done  = s.meas_active && frame_rise && !ref_edge;
		delay_val  = {s.meas_cnt[11:2], 2'b00};
		delay_diff = (delay_val >= s.prev_delay) ? delay_val - s.prev_delay
		                                         : s.prev_delay - delay_val;
		window_eff = {6'h00, s.window[5:2], 2'b00};
		jit_event  = meas_done && s.have_prev && (delay_diff > window_eff);
		realign    = ref_edge && ((s.mode == system_reference_monitor_pkg::MODE_CONTINUOUS) ||
		                          (s.mode == system_reference_monitor_pkg::MODE_ONE_SHOT));
		snapshot   = wr_at(reg_write, reg_addr, `ADDR_DELAY_LOW) ||
		             wr_at(reg_write, reg_addr, `ADDR_DELAY_HIGH) ||
		             wr_at(reg_write, reg_addr, `ADDR_PHASE_LOW) ||
		             wr_at(reg_write, reg_addr, `ADDR_PHASE_HIGH);
		in_gate    = s.tx_gating[`BIT_PIN_INPUT_GATE] ? tx_enable
		                                              : s.tx_gating[`BIT_SW_INPUT_GATE];
		out_gate   = s.tx_gating[`BIT_PIN_OUTPUT_GATE] ? tx_enable
		                                               : s.tx_gating[`BIT_SW_OUTPUT_GATE];
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s          = s;
		next_s.ref_prev = system_reference;
		next_s.rdata    = reg_read ? read_mux(reg_addr, s) : s.rdata;

		// Multiframe clock, realigned by the reference when the mode asks
		if (realign) begin
			next_s.frame_cnt = 12'h000;
		end else if (s.frame_cnt == FRAME_LAST) begin
			next_s.frame_cnt = 12'h000;
		end else begin
			next_s.frame_cnt = s.frame_cnt + 12'h001;
		end
		next_s.frame_clk = (next_s.frame_cnt == 12'h000);

		// One realignment only, then back to monitoring
		if (ref_edge && s.mode == system_reference_monitor_pkg::MODE_ONE_SHOT) begin
			next_s.mode = system_reference_monitor_pkg::MODE_MONITOR;
		end

		// Delay from reference edge to the next multiframe rising edge
		if (ref_edge) begin
			next_s.meas_active = 1'b1;
			next_s.meas_cnt    = 12'h000;
		end else if (meas_done) begin
			next_s.meas_active = 1'b0;
			next_s.live_delay  = delay_val;
			next_s.prev_delay  = delay_val;
			next_s.have_prev   = 1'b1;
		end else if (s.meas_active && s.meas_cnt != `DELAY_MAX) begin
			next_s.meas_cnt = s.meas_cnt + 12'h001;
		end

		if (snapshot) begin
			next_s.snap_delay = s.live_delay;
			next_s.snap_phase = ref_phase_value;
		end

		// Pulse count; a pulse in the clearing cycle is kept
		if (wr_at(reg_write, reg_addr, `ADDR_PULSE_COUNT)) begin
			next_s.pulse_count = ref_edge ? 8'h01 : 8'h00;
		end else if (ref_edge) begin
			next_s.pulse_count = s.pulse_count + 8'h01;
		end

		// Sticky jitter flag, set wins over the write-one clear
		next_s.jit_flag = (s.jit_flag &&
		                   !(wr_at(reg_write, reg_addr, `ADDR_IRQ_STATUS) &&
		                     reg_wdata[`BIT_JITTER])) || jit_event;

		if (reg_write) begin
			case (reg_addr)
				`ADDR_IRQ_ENABLE:    next_s.jit_enable = reg_wdata[`BIT_JITTER];
				`ADDR_JITTER_WINDOW: next_s.window     = reg_wdata[5:0];
				`ADDR_SYNC_CONTROL:  next_s.mode = system_reference_monitor_pkg::sync_mode_t'(reg_wdata[1:0]);
				`ADDR_TX_GATING:     next_s.tx_gating  = {reg_wdata[7:6], 2'h0, reg_wdata[3:0]};
				`ADDR_BIAS_PD:       next_s.bias_off   = reg_wdata[1:0];
				`ADDR_FSC_LOW:       next_s.fsc_low    = reg_wdata[1:0];
				`ADDR_FSC_HIGH:      next_s.fsc_high   = reg_wdata;
				`ADDR_PHASE_TRIM:    next_s.trim       = reg_wdata[5:0];
				default:             next_s.window     = next_s.window;
			endcase
		end
		next_s.irq = next_s.jit_flag && next_s.jit_enable;

		// Gated data paths and pin-steered controls
		next_s.dp_in   = in_gate ? lane_data : '0;
		next_s.dp_out  = out_gate ? datapath_data : '0;
		next_s.osc_rst = s.tx_gating[`BIT_PIN_OSC_RESET] ? tx_enable
		                                                 : (|hop_mode_bits);
		if (s.tx_gating[`BIT_PIN_CURRENT]) begin
			next_s.fsc_out = tx_enable ? {s.fsc_high, s.fsc_low} : 10'h000;
		end else begin
			next_s.fsc_out = {s.fsc_high, s.fsc_low};
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s           <= '0;
			s.mode      <= system_reference_monitor_pkg::MODE_MONITOR;
			s.tx_gating <= `RST_TX_GATING;
			s.bias_off  <= `RST_BIAS_PD;
			s.fsc_low   <= `RST_FSC_LOW;
			s.fsc_high  <= `RST_FSC_HIGH;
			s.fsc_out   <= {`RST_FSC_HIGH, `RST_FSC_LOW};
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata        = s.rdata;
	assign multiframe_clock = s.frame_clk;
	assign jitter_irq       = s.irq;
	assign datapath_in_data = s.dp_in;
	assign core_data        = s.dp_out;
	assign osc_reset        = s.osc_rst;
	assign full_scale_code  = s.fsc_out;
	assign core_bias_off    = s.bias_off;
	assign clock_phase_trim = s.trim;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	sequence one_shot_hit;
		ref_edge && s.mode == system_reference_monitor_pkg::MODE_ONE_SHOT && !reg_write;
	endsequence

	sequence realigned_then_monitor;
		s.frame_cnt == 12'h000 && s.mode == system_reference_monitor_pkg::MODE_MONITOR;
	endsequence

	AST_DELAY_LSB_ZERO:
	assert property (meas_done |=> s.live_delay[1:0] == 2'b00 && s.live_delay == $past(delay_val))
		else $error("Measured delay wrong or low bits set");

	AST_SNAPSHOT:
	assert property (snapshot |=> s.snap_delay == $past(s.live_delay) &&
	                 s.snap_phase == $past(ref_phase_value))
		else $error("Snapshot did not capture measurements");

	AST_COUNT:
	assert property (wr_at(reg_write, reg_addr, `ADDR_PULSE_COUNT) |=>
	                 s.pulse_count == {7'h00, $past(ref_edge)})
		else $error("Pulse count not cleared by write");

	AST_WINDOW_QUIET:
	assert property (meas_done && s.have_prev && delay_diff <= {6'h00, s.window[5:2], 2'b00}
	                 |-> !jit_event)
		else $error("Jitter event inside window");

	AST_JITTER_SET:
	assert property (meas_done && s.have_prev && delay_diff > {6'h00, s.window[5:2], 2'b00}
	                 |=> s.jit_flag)
		else $error("Jitter beyond window not flagged");

	AST_CONTINUOUS:
	assert property (ref_edge && s.mode == system_reference_monitor_pkg::MODE_CONTINUOUS |=>
	                 s.frame_cnt == 12'h000 && multiframe_clock)
		else $error("Continuous mode did not realign");

	AST_ONE_SHOT:
	assert property (one_shot_hit |=> realigned_then_monitor)
		else $error("One-shot did not realign and revert");

	AST_INPUT_GATE:
	assert property (!s.tx_gating[`BIT_PIN_INPUT_GATE] |=>
	                 datapath_in_data == ($past(s.tx_gating[`BIT_SW_INPUT_GATE]) ?
	                                      $past(lane_data) : '0))
		else $error("Input gate wrong");

	AST_OUTPUT_GATE:
	assert property (s.tx_gating[`BIT_PIN_OUTPUT_GATE] && !tx_enable |=> core_data == '0)
		else $error("Pin did not block output data");

	AST_OSC_RESET:
	assert property (s.tx_gating[`BIT_PIN_OSC_RESET] |=> osc_reset == $past(tx_enable))
		else $error("Oscillator reset not from pin");

	AST_FSC_PIN:
	assert property (s.tx_gating[`BIT_PIN_CURRENT] && tx_enable |=>
	                 full_scale_code[9:2] == $past(s.fsc_high) &&
	                 full_scale_code[1:0] == $past(s.fsc_low))
		else $error("Full-scale code not passed with pin high");

	AST_FSC_REG:
	assert property (!s.tx_gating[`BIT_PIN_CURRENT] |=>
	                 full_scale_code[9:2] == $past(s.fsc_high) &&
	                 full_scale_code[1:0] == $past(s.fsc_low))
		else $error("Full-scale code not from registers");

	AST_SW_OUTPUT_GATE:
	assert property (!s.tx_gating[`BIT_PIN_OUTPUT_GATE] |=>
	                 core_data == ($past(s.tx_gating[`BIT_SW_OUTPUT_GATE]) ?
	                               $past(datapath_data) : '0))
		else $error("Output gate bit not obeyed");

	AST_PIN_INPUT_GATE:
	assert property (s.tx_gating[`BIT_PIN_INPUT_GATE] |=>
	                 datapath_in_data == ($past(tx_enable) ? $past(lane_data) : '0))
		else $error("Pin did not steer input data");

	AST_COUNT_STEP:
	assert property (ref_edge && !wr_at(reg_write, reg_addr, `ADDR_PULSE_COUNT) |=>
	                 s.pulse_count == $past(s.pulse_count) + 8'h01)
		else $error("Reference pulse not counted");

	AST_SPARE_NO_REALIGN:
	assert property (ref_edge && s.mode == system_reference_monitor_pkg::MODE_SPARE &&
	                 s.frame_cnt != FRAME_LAST |=> s.frame_cnt != 12'h000)
		else $error("Spare mode code realigned");

	AST_JITTER_CLEAR:
	assert property (wr_at(reg_write, reg_addr, `ADDR_IRQ_STATUS) && reg_wdata[`BIT_JITTER] &&
	                 !jit_event |=> !s.jit_flag && !jitter_irq)
		else $error("Jitter flag not cleared");

endmodule

// *** tb/reg_host_model.sv ***
// Host side of the register port: byte writes and reads, one strobe each.
// Assumes the bench calls its tasks after reset is released and mclk runs.
`timescale 1ns/10ps

module reg_host_model (
	// Clock
	input  wire logic        mclk,
	// Register port
	output logic      [11:0] reg_addr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_write,
	output logic             reg_read,
	input  wire logic [7:0]  reg_rdata
);
	initial begin
		reg_addr  = 12'h000;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read  = 1'b0;
	end

	// Snapshot requests and flag clearing are both plain writes
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr  = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge mclk);
		#1;
		reg_write = 1'b0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge mclk);
		#1;
		reg_read = 1'b0;
		@(posedge mclk);
		#1;
		d = reg_rdata;
	endtask
endmodule

// *** tb/system_reference_monitor_tx_gating_regs_tb_top.sv ***
// Self-checking bench of the reference monitor and transmit gating registers.
// Assumes the host model drives the register port and mclk is the only clock.
`timescale 1ns/10ps

module system_reference_monitor_tx_gating_regs_tb_top;
	localparam int FP = 16;
	logic        mclk             = 1'b0;
	logic        reset_n          = 1'b0;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [7:0]  reg_rdata;
	logic        system_reference = 1'b0;
	logic [11:0] ref_phase_value  = 12'h000;
	logic        multiframe_clock;
	logic        jitter_irq;
	logic        tx_enable        = 1'b0;
	logic [1:0]  hop_mode_bits    = 2'h0;
	logic [15:0] lane_data        = 16'h1234;
	logic [15:0] datapath_data    = 16'hbeef;
	logic [15:0] datapath_in_data;
	logic [15:0] core_data;
	logic        osc_reset;
	logic [9:0]  full_scale_code;
	logic [1:0]  core_bias_off;
	logic [5:0]  clock_phase_trim;
	logic        seen;
	int          error_cnt        = 0;
	int          n_compared       = 0;
	logic [11:0] rst_a [10] = '{12'h03f, 12'h040, 12'h041, 12'h042, 12'h07f,
		12'h039, 12'h03a, 12'h036, 12'h034, 12'h050};
	logic [7:0]  rst_d [10] = '{8'hc0, 8'h03, 8'h03, 8'hff, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	always #5 mclk = ~mclk;

	system_reference_monitor_tx_gating_regs #(.DATA_W(16), .FRAME_PERIOD(FP)) dut (
		.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.system_reference(system_reference), .ref_phase_value(ref_phase_value),
		.multiframe_clock(multiframe_clock), .jitter_irq(jitter_irq),
		.tx_enable(tx_enable), .hop_mode_bits(hop_mode_bits), .lane_data(lane_data),
		.datapath_data(datapath_data), .datapath_in_data(datapath_in_data),
		.core_data(core_data), .osc_reset(osc_reset), .full_scale_code(full_scale_code),
		.core_bias_off(core_bias_off), .clock_phase_trim(clock_phase_trim));

	reg_host_model host (
		.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic close_out();
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd(a, v);
		chk(16'(v), 16'(e));
	endtask

	// Waits for a frame start, then raises the reference k cycles later
	task automatic ref_pulse(input int k, output logic mf);
		int n;
		n = 0;
		while (multiframe_clock !== 1'b1 && n < 4 * FP) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 4 * FP)
			chk(16'h0000, 16'h0001);
		repeat (k) @(posedge mclk);
		#1;
		system_reference = 1'b1;
		@(posedge mclk);
		#1;
		system_reference = 1'b0;
		mf = multiframe_clock;
		@(posedge mclk);
		#1;
		mf = mf | multiframe_clock;
	endtask

	task automatic gate_chk(input logic [7:0] v, input logic te, input logic [1:0] hop,
		input logic [15:0] e_in, input logic [15:0] e_core, input logic e_osc,
		input logic [9:0] e_fsc);
		host.wr(12'h03f, v);
		tx_enable = te;
		hop_mode_bits = hop;
		repeat (2) @(posedge mclk);
		#1;
		chk(datapath_in_data, e_in);
		chk(core_data, e_core);
		chk(16'(osc_reset), 16'(e_osc));
		chk(16'(full_scale_code), 16'(e_fsc));
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		for (int i = 0; i < 10; i++)
			rd_chk(rst_a[i], rst_d[i]);
		chk(16'(full_scale_code), 16'h03ff);
		chk(16'(core_bias_off), 16'h0003);
		gate_chk(8'hc0, 1'b0, 2'h0, 16'h1234, 16'hbeef, 1'b0, 10'h3ff);
		gate_chk(8'h40, 1'b0, 2'h1, 16'h1234, 16'h0000, 1'b1, 10'h3ff);
		gate_chk(8'h80, 1'b0, 2'h2, 16'h0000, 16'hbeef, 1'b1, 10'h3ff);
		gate_chk(8'h0f, 1'b1, 2'h0, 16'h1234, 16'hbeef, 1'b1, 10'h3ff);
		gate_chk(8'h0f, 1'b0, 2'h3, 16'h0000, 16'h0000, 1'b0, 10'h000);
		gate_chk(8'h00, 1'b1, 2'h0, 16'h0000, 16'h0000, 1'b0, 10'h3ff);
		host.wr(12'h03f, 8'hff);
		rd_chk(12'h03f, 8'hcf);
		host.wr(12'h042, 8'h5a);
		host.wr(12'h041, 8'hfd);
		rd_chk(12'h041, 8'h01);
		chk(16'(full_scale_code), 16'h0169);
		host.wr(12'h040, 8'hfe);
		rd_chk(12'h040, 8'h02);
		chk(16'(core_bias_off), 16'h0002);
		host.wr(12'h07f, 8'hff);
		rd_chk(12'h07f, 8'h3f);
		chk(16'(clock_phase_trim), 16'h003f);
		host.wr(12'h039, 8'hff);
		rd_chk(12'h039, 8'h3f);
		host.wr(12'h036, 8'h00);
		for (int i = 0; i < 3; i++) begin
			ref_pulse(5, seen);
			chk(16'(seen), 16'h0000);
		end
		rd_chk(12'h036, 8'h03);
		host.wr(12'h036, 8'h55);
		rd_chk(12'h036, 8'h00);
		host.wr(12'h03a, 8'h01);
		ref_pulse(5, seen);
		chk(16'(seen), 16'h0001);
		rd_chk(12'h03a, 8'h01);
		host.wr(12'h03a, 8'h02);
		ref_pulse(5, seen);
		chk(16'(seen), 16'h0001);
		rd_chk(12'h03a, 8'h00);
		ref_pulse(5, seen);
		chk(16'(seen), 16'h0000);
		host.wr(12'h03a, 8'h03);
		ref_pulse(5, seen);
		chk(16'(seen), 16'h0000);
		ref_phase_value = 12'h0ff;
		host.wr(12'h037, 8'h00);
		rd_chk(12'h037, 8'hff);
		rd_chk(12'h038, 8'h00);
		ref_phase_value = 12'hfff;
		rd_chk(12'h037, 8'hff);
		host.wr(12'h035, 8'h00);
		rd_chk(12'h038, 8'h0f);
		// Last pulse came 6 cycles into a 16-cycle frame: 10 cycles, low bits cleared
		rd_chk(12'h034, 8'h08);
		rd_chk(12'h035, 8'h00);
		host.wr(12'h039, 8'h03);
		host.wr(12'h020, 8'h10);
		rd_chk(12'h020, 8'h10);
		host.wr(12'h024, 8'h10);
		rd_chk(12'h024, 8'h00);
		for (int i = 0; i < 3; i++)
			ref_pulse(2 + 8 * (i % 2), seen);
		// Let the last measurement finish so no event is left pending
		repeat (FP) @(posedge mclk);
		rd_chk(12'h024, 8'h10);
		chk(16'(jitter_irq), 16'h0001);
		host.wr(12'h020, 8'h00);
		rd_chk(12'h024, 8'h10);
		chk(16'(jitter_irq), 16'h0000);
		host.wr(12'h024, 8'h10);
		rd_chk(12'h024, 8'h00);
		host.wr(12'h039, 8'h3f);
		for (int i = 0; i < 3; i++)
			ref_pulse(2 + 8 * (i % 2), seen);
		repeat (FP) @(posedge mclk);
		rd_chk(12'h024, 8'h00);
		close_out();
	end

	// Cuts a hang short well after the expected few hundred cycles
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule
